// file: rtl/rclm_pkg.sv
package rclm_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_PRESET0 = 8'h04;
  localparam logic [7:0] OFS_CEILING = 8'h14;
  localparam logic [7:0] OFS_SKIP_BW = 8'h18;
  localparam logic [7:0] OFS_SKIP0 = 8'h1c;
  localparam logic [7:0] OFS_CUR_LOW = 8'h2c;
  localparam logic [7:0] OFS_CUR_HIGH = 8'h30;
  localparam logic [7:0] OFS_FREQ_LOW = 8'h34;
  localparam logic [7:0] OFS_FREQ_HIGH = 8'h38;
  localparam logic [7:0] OFS_REF_FLOOR = 8'h3c;
  localparam logic [7:0] OFS_REF_CEIL = 8'h40;
  localparam logic [7:0] OFS_ROUTE = 8'h44;
  localparam logic [7:0] OFS_STATUS = 8'h48;
  localparam logic [7:0] OFS_RESULT = 8'h4c;

  // mode register fields
  localparam int MODE_COMB_LSB = 0;
  localparam int MODE_NOLOAD_BIT = 2;
  // route register fields, four warning bits per destination
  localparam int ROUTE_A_LSB = 0;
  localparam int ROUTE_B_LSB = 4;
  localparam int ROUTE_RELAY_LSB = 8;

  // presets in 0.01 %, frequencies in 0.1 Hz, ceiling in 0.001 x rated
  localparam logic signed [15:0] PRESET_MIN = 16'shd8f0;
  localparam logic signed [15:0] PRESET_MAX = 16'sh2710;
  localparam logic signed [15:0] PRESET_RST = 16'sh0000;
  localparam logic signed [63:0] PCT_DIV = 64'sh0000_0000_0000_2710;
  localparam logic [15:0] CEIL_MIN = 16'h0064;
  localparam logic [15:0] CEIL_MAX = 16'h044c;
  localparam logic [15:0] CEIL_RST = 16'h03e8;
  localparam logic [31:0] CEIL_DIV = 32'h0000_03e8;
  localparam logic [15:0] SKIP_BW_MAX = 16'h03e8;
  localparam logic [15:0] SKIP_BW_RST = 16'h0000;
  localparam logic [15:0] FREQ_MAX = 16'h04b0;
  localparam logic [15:0] SKIP_RST = 16'h04b0;
  localparam logic [15:0] CUR_LOW_RST = 16'h0000;
  localparam logic [15:0] FREQ_LOW_RST = 16'h0000;
  localparam logic [15:0] FREQ_HIGH_RST = 16'h04b0;
  localparam logic signed [31:0] REF_FLOOR_RST = 32'sh0000_0000;
  localparam logic [1:0] NOLOAD_TRIP = 2'h0;

  typedef enum logic [1:0] {
    RCLM_SUM,
    RCLM_RELATIVE,
    RCLM_EXT_PRESET
  } rclm_comb_t;

  typedef struct packed {
    logic cur_low;
    logic cur_high;
    logic freq_low;
    logic freq_high;
  } rclm_warn_t;

  function automatic logic [15:0] rclm_clamp_u(logic [15:0] lo, logic [15:0] hi,
                                               logic [15:0] v);
    rclm_clamp_u = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic signed [31:0] rclm_clamp_s(logic signed [31:0] lo,
                                                      logic signed [31:0] hi,
                                                      logic signed [31:0] v);
    rclm_clamp_s = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

endpackage

// file: rtl/rclm_limit_cmp.sv
`timescale 1ns/100ps
module rclm_limit_cmp #(
  parameter int W = 16,
  parameter bit ABOVE = 1'b0
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] limit,
  input wire logic armed,
  output logic hit
);
  // strict compare, an equal value is not a violation
  assign hit = armed & (ABOVE ? (value > limit) : (value < limit));
endmodule

// file: rtl/rclm_top.sv
// Summary of operation
// - sum mode adds preset percent of span
// - relative mode adds preset percent of external
// - switched mode picks external or span preset
// - external reference sums analog, pulse, serial
// - one preset always active, resets zero
// - four signed presets within plus/minus 100%
// - two select pins pick preset one-four
// - current ceiling 0.1-1.1 rated, reset rated
// - one skip bandwidth, zero disables, resets zero
// - keep reference out of each skip band
// - four skip centres 0-120 Hz, reset 120
// - low current warns or trips per action
// - warnings armed only after reaching reference
// - warnings routed to two outputs and relay
// - high current warning, limit up to max
// - low frequency warning, limit resets zero
// - high frequency warning, limit resets 120
// - clamp reference at floor unless local
// - clamp reference at ceiling unless local
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module rclm_top #(
  parameter logic [15:0] RATED_CURRENT = 16'h0064,
  parameter logic [15:0] MAX_CURRENT = 16'h00a0,
  parameter logic signed [31:0] REF_CEIL_RST = 32'sh0000_0258
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [rclm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rclm_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rclm_pkg::DATA_W-1:0] reg_rdata,
  input wire logic preset_sel_hi,
  input wire logic preset_sel_lo,
  input wire logic ext_preset_sel,
  input wire logic signed [31:0] analog_ref_a,
  input wire logic signed [31:0] analog_ref_b,
  input wire logic signed [31:0] pulse_ref,
  input wire logic signed [31:0] serial_ref,
  input wire logic local_ref_active,
  input wire logic signed [31:0] local_ref,
  input wire logic run_cmd,
  input wire logic at_reference,
  input wire logic [15:0] output_freq,
  input wire logic [15:0] motor_current,
  output logic signed [31:0] resulting_ref,
  output logic [15:0] output_current_ceiling,
  output rclm_pkg::rclm_warn_t warn,
  output logic trip_request,
  output logic signal_out_a,
  output logic signal_out_b,
  output logic relay_out
);
  import rclm_pkg::*;
  rclm_comb_t comb_mode;
  logic noload_warn;
  logic signed [15:0] preset [4];
  logic [15:0] ceil_permille;
  logic [15:0] skip_bw;
  logic [15:0] skip_band_centre [4];
  logic [15:0] current_low_limit;
  logic [15:0] current_high_limit;
  logic [15:0] freq_low_limit;
  logic [15:0] freq_high_limit;
  logic signed [31:0] reference_floor;
  logic signed [31:0] reference_ceiling;
  logic [11:0] route;
  logic armed;
  logic [2:0] pin_s1, pin_s2, pin_s3, pin_q;
  // pins cross in through three flops; a bit moves only when stages 2 and 3 agree
  wire [2:0] pins_raw = {ext_preset_sel, preset_sel_hi, preset_sel_lo};
  wire [2:0] next_pin_q = (pin_s2 & pin_s3) | (pin_q & (pin_s2 | pin_s3));
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pin_q <= 3'h0;
    end else begin
      pin_s1 <= pins_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q <= next_pin_q;
    end
  end

  // register write decode
  wire wr_mode = reg_wr && reg_addr == OFS_MODE;
  wire wr_ceil = reg_wr && reg_addr == OFS_CEILING;
  wire wr_bw = reg_wr && reg_addr == OFS_SKIP_BW;
  wire wr_cur_low = reg_wr && reg_addr == OFS_CUR_LOW;
  wire wr_cur_high = reg_wr && reg_addr == OFS_CUR_HIGH;
  wire wr_freq_low = reg_wr && reg_addr == OFS_FREQ_LOW;
  wire wr_freq_high = reg_wr && reg_addr == OFS_FREQ_HIGH;
  wire wr_floor = reg_wr && reg_addr == OFS_REF_FLOOR;
  wire wr_ceiling = reg_wr && reg_addr == OFS_REF_CEIL;
  wire wr_route = reg_wr && reg_addr == OFS_ROUTE;
  wire [1:0] wr_comb = reg_wdata[MODE_COMB_LSB +: 2];
  wire [15:0] wd16 = reg_wdata[15:0];
  wire signed [15:0] wd_s16 = reg_wdata[15:0];
  wire signed [31:0] wd_s32 = reg_wdata;

  // out-of-range writes are clamped instead of refused, except a combining code above 2, which leaves comb_mode unchanged; limits stay ordered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      comb_mode <= RCLM_SUM;
      noload_warn <= 1'b0;
      ceil_permille <= CEIL_RST;
      skip_bw <= SKIP_BW_RST;
      current_low_limit <= CUR_LOW_RST;
      current_high_limit <= MAX_CURRENT;
      freq_low_limit <= FREQ_LOW_RST;
      freq_high_limit <= FREQ_HIGH_RST;
      reference_floor <= REF_FLOOR_RST;
      reference_ceiling <= REF_CEIL_RST;
      route <= 12'h000;
    end else begin
      if (wr_mode && wr_comb <= 2'h2) begin
        comb_mode <= rclm_comb_t'(wr_comb);
      end
      if (wr_mode) begin
        noload_warn <= reg_wdata[MODE_NOLOAD_BIT];
      end
      if (wr_ceil) begin
        ceil_permille <= rclm_clamp_u(CEIL_MIN, CEIL_MAX, wd16);
      end
      if (wr_bw) begin
        skip_bw <= rclm_clamp_u(16'h0000, SKIP_BW_MAX, wd16);
      end
      if (wr_cur_low) begin
        current_low_limit <= rclm_clamp_u(16'h0000, current_high_limit, wd16);
      end
      if (wr_cur_high) begin
        current_high_limit <= rclm_clamp_u(current_low_limit, MAX_CURRENT, wd16);
      end
      if (wr_freq_low) begin
        freq_low_limit <= rclm_clamp_u(16'h0000, freq_high_limit, wd16);
      end
      if (wr_freq_high) begin
        freq_high_limit <= rclm_clamp_u(freq_low_limit, FREQ_MAX, wd16);
      end
      if (wr_floor) begin
        reference_floor <= rclm_clamp_s(32'sh8000_0000, reference_ceiling, wd_s32);
      end
      if (wr_ceiling) begin
        reference_ceiling <= rclm_clamp_s(reference_floor, 32'sh7fff_ffff, wd_s32);
      end
      if (wr_route) begin
        route <= reg_wdata[11:0];
      end
    end
  end

  // repeated preset and skip-centre registers
  for (genvar i = 0; i < 4; i++) begin : g_slot
    wire wr_preset = reg_wr && reg_addr == OFS_PRESET0 + 8'(4 * i);
    wire wr_skip = reg_wr && reg_addr == OFS_SKIP0 + 8'(4 * i);
    always_ff @(posedge core_clk) begin
      if (rst) begin
        preset[i] <= PRESET_RST;
        skip_band_centre[i] <= SKIP_RST;
      end else begin
        if (wr_preset) begin
          preset[i] <= 16'(rclm_clamp_s(32'(PRESET_MIN), 32'(PRESET_MAX), 32'(wd_s16)));
        end
        if (wr_skip) begin
          skip_band_centre[i] <= rclm_clamp_u(16'h0000, FREQ_MAX, wd16);
        end
      end
    end
  end

  // reference path
  wire [1:0] preset_idx = pin_q[1:0];
  wire signed [15:0] active_preset = preset[preset_idx];
  wire signed [31:0] ext_sum = analog_ref_a + analog_ref_b + pulse_ref + serial_ref;
  wire signed [31:0] span = reference_ceiling - reference_floor;
  wire signed [63:0] pct_span = 64'(active_preset) * 64'(span) / PCT_DIV;
  wire signed [63:0] pct_ext = 64'(active_preset) * 64'(ext_sum) / PCT_DIV;
  wire signed [31:0] contrib_span = 32'(pct_span);
  wire signed [31:0] contrib_ext = 32'(pct_ext);
  logic signed [31:0] combined;
  logic signed [31:0] skipped;
  logic signed [31:0] next_ref;
  // the floor is an additive base term in every combining mode
  always_comb begin
    case (comb_mode)
      RCLM_SUM: combined = reference_floor + ext_sum + contrib_span;
      RCLM_RELATIVE: combined = reference_floor + ext_sum + contrib_ext;
      RCLM_EXT_PRESET: combined = reference_floor + (pin_q[2] ? contrib_span : ext_sum);
      default: combined = reference_floor + ext_sum + contrib_span;
    endcase
  end
  // a value inside a band goes to the nearer edge; bands are walked in order
  always_comb begin
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    lo = 32'sh0;
    hi = 32'sh0;
    skipped = combined;
    for (int i = 0; i < 4; i++) begin
      lo = 32'(skip_band_centre[i]) - 32'(skip_bw >> 1);
      hi = 32'(skip_band_centre[i]) + 32'(skip_bw >> 1);
      if (skip_bw != 16'h0000 && skipped > lo && skipped < hi) begin
        // signed compare, so a negative value still goes to the low edge
        skipped = (skipped < $signed(32'(skip_band_centre[i]))) ? lo : hi;
      end
    end
  end
  // floor and ceiling win over the skip bands; local reference bypasses both
  assign next_ref = local_ref_active ? local_ref
                  : rclm_clamp_s(reference_floor, reference_ceiling, skipped);
  wire [31:0] ceil_amps = 32'(RATED_CURRENT) * 32'(ceil_permille) / CEIL_DIV;
  // limit monitors
  logic hit_cur_low, hit_cur_high, hit_freq_low, hit_freq_high;
  rclm_limit_cmp #(.W(16), .ABOVE(1'b0)) u_cur_low (
    .value(motor_current), .limit(current_low_limit), .armed(armed), .hit(hit_cur_low));
  rclm_limit_cmp #(.W(16), .ABOVE(1'b1)) u_cur_high (
    .value(motor_current), .limit(current_high_limit), .armed(armed), .hit(hit_cur_high));
  rclm_limit_cmp #(.W(16), .ABOVE(1'b0)) u_freq_low (
    .value(output_freq), .limit(freq_low_limit), .armed(armed), .hit(hit_freq_low));
  rclm_limit_cmp #(.W(16), .ABOVE(1'b1)) u_freq_high (
    .value(output_freq), .limit(freq_high_limit), .armed(armed), .hit(hit_freq_high));
  rclm_warn_t next_warn;
  assign next_warn.cur_low = hit_cur_low & noload_warn;
  assign next_warn.cur_high = hit_cur_high;
  assign next_warn.freq_low = hit_freq_low;
  assign next_warn.freq_high = hit_freq_high;
  wire next_trip = hit_cur_low & ~noload_warn;
  wire next_armed = run_cmd & (armed | at_reference);
  wire [3:0] route_a = route[ROUTE_A_LSB +: 4];
  wire [3:0] route_b = route[ROUTE_B_LSB +: 4];
  wire [3:0] route_relay = route[ROUTE_RELAY_LSB +: 4];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      armed <= 1'b0;
      warn <= '0;
      trip_request <= 1'b0;
      signal_out_a <= 1'b0;
      signal_out_b <= 1'b0;
      relay_out <= 1'b0;
      resulting_ref <= 32'sh0;
      output_current_ceiling <= 16'h0000;
    end else begin
      armed <= next_armed;
      warn <= next_warn;
      trip_request <= next_trip;
      signal_out_a <= |(next_warn & route_a);
      signal_out_b <= |(next_warn & route_b);
      relay_out <= |(next_warn & route_relay);
      resulting_ref <= next_ref;
      output_current_ceiling <= ceil_amps[15:0];
    end
  end
  // read mux; unmapped offsets read zero
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (reg_addr)
      OFS_MODE: rd_mux = {29'h0, noload_warn, comb_mode};
      OFS_CEILING: rd_mux = {16'h0, ceil_permille};
      OFS_SKIP_BW: rd_mux = {16'h0, skip_bw};
      OFS_CUR_LOW: rd_mux = {16'h0, current_low_limit};
      OFS_CUR_HIGH: rd_mux = {16'h0, current_high_limit};
      OFS_FREQ_LOW: rd_mux = {16'h0, freq_low_limit};
      OFS_FREQ_HIGH: rd_mux = {16'h0, freq_high_limit};
      OFS_REF_FLOOR: rd_mux = reference_floor;
      OFS_REF_CEIL: rd_mux = reference_ceiling;
      OFS_ROUTE: rd_mux = {20'h0, route};
      OFS_STATUS: rd_mux = {23'h0, pin_q, armed, trip_request, warn};
      OFS_RESULT: rd_mux = resulting_ref;
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (reg_addr == OFS_PRESET0 + 8'(4 * i)) rd_mux = 32'(preset[i]);
          if (reg_addr == OFS_SKIP0 + 8'(4 * i)) rd_mux = {16'h0, skip_band_centre[i]};
        end
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_idle_then_reach;
    !armed ##1 (run_cmd && at_reference);
  endsequence
  property p_arm;
    s_idle_then_reach |=> armed;
  endproperty
  a_arm: assert property (p_arm) else $error("warnings not armed at reference");
  property p_disarmed_quiet;
    !armed |=> (warn == '0) && !trip_request && !signal_out_a && !relay_out;
  endproperty
  a_disarmed_quiet: assert property (p_disarmed_quiet) else $error("warning while disarmed");
  property p_preset_sel;
    (pin_s2[1:0] == pin_s3[1:0]) |=> preset_idx == $past(pin_s3[1:0]);
  endproperty
  a_preset_sel: assert property (p_preset_sel) else $error("wrong preset selected");
  property p_floor;
    !local_ref_active |=> resulting_ref >= $past(reference_floor);
  endproperty
  a_floor: assert property (p_floor) else $error("reference below floor");
  property p_ceiling;
    !local_ref_active |=> resulting_ref <= $past(reference_ceiling);
  endproperty
  a_ceiling: assert property (p_ceiling) else $error("reference above ceiling");
  property p_cur_high_strict;
    warn.cur_high |-> $past(motor_current) > $past(current_high_limit);
  endproperty
  a_cur_high_strict: assert property (p_cur_high_strict) else $error("high current unjustified");
  property p_trip;
    (armed && motor_current < current_low_limit && !noload_warn)
      |=> trip_request && !warn.cur_low;
  endproperty
  a_trip: assert property (p_trip) else $error("no-load trip missing");
  property p_route;
    ##1 signal_out_b == |(warn & $past(route_b));
  endproperty
  a_route: assert property (p_route) else $error("signal output b misrouted");
  property p_preset_range;
    preset[0] >= PRESET_MIN && preset[3] <= PRESET_MAX && preset[1] >= PRESET_MIN;
  endproperty
  a_preset_range: assert property (p_preset_range) else $error("preset out of range");
  property p_reset_values;
    $past(rst) |-> preset[2] == PRESET_RST && skip_bw == SKIP_BW_RST
      && skip_band_centre[1] == SKIP_RST;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");
endmodule

// file: dv/rclm_far_model.sv
`timescale 1ns/100ps
module rclm_far_model (
  input wire logic core_clk,
  input wire logic [1:0] sel_code,
  input wire logic use_preset,
  input wire logic signed [31:0] ref_a_cmd,
  input wire logic signed [31:0] ref_b_cmd,
  input wire logic signed [31:0] ref_p_cmd,
  input wire logic signed [31:0] ref_s_cmd,
  output logic preset_sel_hi,
  output logic preset_sel_lo,
  output logic ext_preset_sel,
  output logic signed [31:0] analog_ref_a,
  output logic signed [31:0] analog_ref_b,
  output logic signed [31:0] pulse_ref,
  output logic signed [31:0] serial_ref
);
  // pins move only after an edge, as a real switch bank seen through the sync
  always @(posedge core_clk) begin
    preset_sel_hi <= sel_code[1];
    preset_sel_lo <= sel_code[0];
    ext_preset_sel <= use_preset;
    analog_ref_a <= ref_a_cmd;
    analog_ref_b <= ref_b_cmd;
    pulse_ref <= ref_p_cmd;
    serial_ref <= ref_s_cmd;
  end
endmodule

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench;
  import rclm_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [1:0] sel_code = 2'h0;
  logic use_preset = 1'b0;
  logic signed [31:0] ra = 32'sh0, rb = 32'sh0, rp = 32'sh0, rs = 32'sh0;
  logic sel_hi, sel_lo, ext_sel;
  logic signed [31:0] a_ref, b_ref, p_ref, s_ref, resulting_ref;
  logic local_act = 1'b0;
  logic signed [31:0] local_ref = 32'sh0;
  logic run_cmd = 1'b0;
  logic at_ref = 1'b0;
  logic [15:0] ofreq = 16'h0000;
  logic [15:0] mcur = 16'h0000;
  logic [15:0] ceil_out;
  rclm_warn_t warn;
  logic trip, out_a, out_b, relay;
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  always #5 core_clk = ~core_clk;
  rclm_far_model far (.core_clk(core_clk), .sel_code(sel_code), .use_preset(use_preset),
    .ref_a_cmd(ra), .ref_b_cmd(rb), .ref_p_cmd(rp), .ref_s_cmd(rs),
    .preset_sel_hi(sel_hi), .preset_sel_lo(sel_lo), .ext_preset_sel(ext_sel),
    .analog_ref_a(a_ref), .analog_ref_b(b_ref), .pulse_ref(p_ref), .serial_ref(s_ref));
  rclm_top dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .preset_sel_hi(sel_hi),
    .preset_sel_lo(sel_lo), .ext_preset_sel(ext_sel), .analog_ref_a(a_ref),
    .analog_ref_b(b_ref), .pulse_ref(p_ref), .serial_ref(s_ref),
    .local_ref_active(local_act), .local_ref(local_ref), .run_cmd(run_cmd),
    .at_reference(at_ref), .output_freq(ofreq), .motor_current(mcur),
    .resulting_ref(resulting_ref), .output_current_ceiling(ceil_out), .warn(warn),
    .trip_request(trip), .signal_out_a(out_a), .signal_out_b(out_b), .relay_out(relay));
  task automatic complete_run();
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // hang guard: the whole sequence needs well under two thousand cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // pins pass the far-model flop, a three-flop sync, pin_q and the result register, so six edges with no margin
  task automatic settle();
    repeat (6) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset();
    settle();
    chk(ceil_out, 32'h64);
    rd_chk(OFS_CEILING, 32'h3e8);
    rd_chk(OFS_SKIP_BW, 32'h0);
    for (int i = 0; i < 4; i++) begin
      rd_chk(OFS_PRESET0 + 8'(4 * i), 32'h0);
      rd_chk(OFS_SKIP0 + 8'(4 * i), 32'h4b0);
    end
    rd_chk(OFS_CUR_LOW, 32'h0);
    rd_chk(OFS_CUR_HIGH, 32'ha0);
    rd_chk(OFS_FREQ_LOW, 32'h0);
    rd_chk(OFS_FREQ_HIGH, 32'h4b0);
    rd_chk(OFS_REF_CEIL, 32'h258);
    $display("test reset done");
  endtask
  task automatic t_combine();
    wr(OFS_REF_FLOOR, 32'h64);
    wr(OFS_REF_CEIL, 32'h1f4);
    wr(OFS_PRESET0, 32'h9c4);
    ra <= 50; rb <= 30; rp <= 20; rs <= 60;
    settle();
    chk(resulting_ref, 100 + 160 + 400 * 2500 / 10000);
    wr(OFS_MODE, 32'h1);
    settle();
    chk(resulting_ref, 100 + 160 + 160 * 2500 / 10000);
    wr(OFS_MODE, 32'h2);
    use_preset <= 1'b1;
    settle();
    chk(resulting_ref, 100 + 400 * 2500 / 10000);
    use_preset <= 1'b0;
    wr(OFS_MODE, 32'h3);
    rd_chk(OFS_MODE, 32'h2);
    settle();
    chk(resulting_ref, 100 + 160);
    wr(OFS_MODE, 32'h0);
    $display("test combine done");
  endtask
  task automatic t_select();
    logic [31:0] exp [4];
    exp = '{360, 160, 300, 100};
    wr(OFS_PRESET0 + 8'h4, 32'hffff_f63c);
    wr(OFS_PRESET0 + 8'h8, 32'h3e8);
    wr(OFS_PRESET0 + 8'hc, 32'hffff_d8f0);
    for (int i = 0; i < 4; i++) begin
      sel_code <= 2'(i);
      settle();
      chk(resulting_ref, exp[i]);
    end
    sel_code <= 2'h0;
    wr(OFS_PRESET0, 32'h4e20);
    rd_chk(OFS_PRESET0, 32'h2710);
    rd_chk(OFS_PRESET0 + 8'h4, 32'hffff_f63c);
    ra <= 1000;
    settle();
    chk(resulting_ref, 32'h1f4);
    local_act <= 1'b1;
    local_ref <= 900;
    settle();
    chk(resulting_ref, 900);
    local_act <= 1'b0;
    $display("test select done");
  endtask
  task automatic t_skip();
    wr(OFS_PRESET0, 32'h0);
    ra <= 220; rb <= 0; rp <= 0; rs <= 0;
    wr(OFS_SKIP0, 32'h12c);
    settle();
    chk(resulting_ref, 320);
    wr(OFS_SKIP_BW, 32'h64);
    settle();
    chk(resulting_ref, 350);
    ra <= 180;
    settle();
    chk(resulting_ref, 250);
    rd_chk(OFS_RESULT, 32'hfa);
    $display("test skip done");
  endtask
  task automatic t_ceiling();
    wr(OFS_CEILING, 32'h1f4);
    settle();
    chk(ceil_out, 100 * 500 / 1000);
    wr(OFS_CEILING, 32'h7d0);
    rd_chk(OFS_CEILING, 32'h44c);
    chk(ceil_out, 100 * 1100 / 1000);
    wr(OFS_CEILING, 32'h32);
    wr(8'hf0, 32'h3e8);
    settle();
    chk(ceil_out, 100 * 100 / 1000);
    $display("test ceiling done");
  endtask
  task automatic t_warn();
    wr(OFS_FREQ_HIGH, 32'h258);
    wr(OFS_FREQ_LOW, 32'h64);
    wr(OFS_CUR_LOW, 32'h32);
    wr(OFS_CUR_HIGH, 32'h78);
    wr(OFS_ROUTE, 32'h814);
    mcur <= 16'd130;
    ofreq <= 16'd601;
    settle();
    chk(warn, 4'h0);
    run_cmd <= 1'b1;
    at_ref <= 1'b1;
    @(posedge core_clk);
    at_ref <= 1'b0;
    settle();
    chk(warn, 4'b0101);
    chk({out_a, out_b, relay}, 3'b110);
    mcur <= 16'd120;
    ofreq <= 16'd600;
    settle();
    chk(warn, 4'h0);
    mcur <= 16'd40;
    ofreq <= 16'd99;
    settle();
    chk({warn, trip, relay}, 6'b0010_10);
    rd_chk(OFS_STATUS, 32'h32);
    wr(OFS_MODE, 32'h4);
    settle();
    chk({warn, trip, relay}, 6'b1010_01);
    run_cmd <= 1'b0;
    settle();
    chk({warn, out_a, out_b, relay}, 7'h0);
    $display("test warn done");
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_combine();
    t_select();
    t_skip();
    t_ceiling();
    t_warn();
    complete_run();
  end
endmodule
